//--- include/exception_prio_map.vh
// Offsets, fields, reset values, ranks and vector numbers of the exception controller
`ifndef EXCEPTION_PRIO_MAP_VH
`define EXCEPTION_PRIO_MAP_VH
// Register byte offsets
`define OFF_CTRL     8'h00
`define OFF_ENABLE   8'h04
`define OFF_PEND_SET 8'h08
`define OFF_PEND_CLR 8'h0c
`define OFF_SYSPRI   8'h10
`define OFF_STATUS   8'h14
`define OFF_IRQPRI0  8'h20
`define OFF_IRQPRI3  8'h2c
// Control fields
`define CTRL_NMI_SET 0
`define CTRL_PSV_SET 1
`define CTRL_PSV_CLR 2
`define CTRL_GRP_LSB 4
`define CTRL_MEM_EN  8
`define CTRL_BUS_EN  9
`define CTRL_USE_EN  10
`define CTRL_DBG_EN  11
`define CTRL_KEEP    32'h00000f30
// Reset values
`define CTRL_RST     32'h00000000
`define PRI_RST      3'h0
// Ranks: smaller is more urgent
`define RANK_RESET   4'h0
`define RANK_NMI     4'h1
`define RANK_HARD    4'h2
`define RANK_SET     4'h3
`define RANK_BASE    4'hf
// Vector numbers
`define VEC_SP       6'h00
`define VEC_RESET    6'h01
`define VEC_NMI      6'h02
`define VEC_HARD     6'h03
`define VEC_MEM      6'h04
`define VEC_BUS      6'h05
`define VEC_USAGE    6'h06
`define VEC_SVC      6'h0b
`define VEC_DEBUG    6'h0c
`define VEC_PSV      6'h0e
`define VEC_TICK     6'h0f
`define VEC_IRQ0     6'h10
// AXI responses
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

//--- logic/exception_priority_controller.v
// Prioritising exception controller with AXI4-Lite registers and core entry sequencing
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "exception_prio_map.vh"

module exception_priority_controller #(
    parameter ADDR_W = 8,   // Register address width
    parameter NEST   = 12   // Deepest handler nesting kept
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire [ADDR_W-1:0] awaddr,
    input  wire              awvalid,
    output reg               awready,
    input  wire [31:0]       wdata,
    input  wire [3:0]        wstrb,
    input  wire              wvalid,
    output reg               wready,
    output reg  [1:0]        bresp,
    output reg               bvalid,
    input  wire              bready,
    input  wire [ADDR_W-1:0] araddr,
    input  wire              arvalid,
    output reg               arready,
    output reg  [31:0]       rdata,
    output reg  [1:0]        rresp,
    output reg               rvalid,
    input  wire              rready,
    input  wire [31:0]       irq_in,
    input  wire              fault_mem,
    input  wire              fault_bus_precise,
    input  wire              fault_bus_imprecise,
    input  wire              fault_usage,
    input  wire              svc_exec,
    input  wire              debug_req,
    input  wire              tick_fire,
    input  wire              first_instr,
    input  wire              stack_done,
    input  wire              vector_done,
    input  wire              handler_return,
    output reg               sp_fetch,
    output reg               vector_fetch,
    output reg  [5:0]        fetch_vector,
    output reg               stack_push,
    output reg               stack_pop,
    output reg               tail_chain,
    output reg               handler_start,
    output reg               handler_mode,
    output reg  [3:0]        exec_prio
);

    // Sequencer states
    localparam S_BOOT  = 3'h0;
    localparam S_RUN   = 3'h1;
    localparam S_ENTRY = 3'h2;
    localparam S_RET   = 3'h3;
    localparam S_UNSTK = 3'h4;

    reg  [31:0]  ctrl_reg;            // Group split and handler enables
    reg  [31:0]  enable_reg;          // Interrupt enables
    reg  [20:0]  syspri_reg;          // Seven 3-bit handler priorities
    reg  [127:0] irqpri_reg;          // 32 nibbles, low 3 bits used
    reg  [47:0]  pend_reg;            // Pending flag per vector
    reg  [47:0]  pend_next;
    reg  [31:0]  irq_meta_reg;        // First synchroniser stage
    reg  [31:0]  irq_sync_reg;        // Second synchroniser stage
    reg  [2:0]   state_reg;           // Sequencer state
    reg  [3:0]   depth_reg;           // Handlers now nested
    reg  [3:0]   rank_stk [0:NEST-1]; // Preempt rank per nesting level
    reg  [5:0]   vec_stk  [0:NEST-1]; // Vector per nesting level
    reg          boot_reg;            // Reset activation still held
    reg          sdone_reg;           // Stacking finished
    reg          vdone_reg;           // Vector fetch finished
    reg  [3:0]   cur_rank;            // Current execution rank
    reg  [3:0]   win_rank;            // Winner preempt rank
    reg  [5:0]   win_vec;             // Winner vector
    reg          win_ok;              // A winner exists
    reg  [12:0]  key;
    reg  [12:0]  best;
    reg  [31:0]  rd_data;
    reg          rd_hit;
    reg          wr_hit;
    integer      i;

    wire [3:0] depth_m1 = depth_reg - 4'h1;
    wire [1:0] grp      = ctrl_reg[`CTRL_GRP_LSB +: 2];
    wire       wr_go    = awvalid & wvalid & ~awready & ~bvalid;
    wire       rd_go    = arvalid & ~arready & ~rvalid;
    wire [7:0] wa       = awaddr[7:0];
    wire [7:0] ra       = araddr[7:0];
    // Write strobe for each location
    wire w_ctrl   = wr_go & (wa == `OFF_CTRL);
    wire w_enable = wr_go & (wa == `OFF_ENABLE);
    wire w_pset   = wr_go & (wa == `OFF_PEND_SET);
    wire w_pclr   = wr_go & (wa == `OFF_PEND_CLR);
    wire w_syspri = wr_go & (wa == `OFF_SYSPRI);
    wire w_irqpri = wr_go & (wa >= `OFF_IRQPRI0) & (wa <= `OFF_IRQPRI3) & (wa[1:0] == 2'h0);
    wire [31:0] wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    wire [31:0] wbits = wdata & wmask;

    // Byte-lane merge of a write into an old word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [31:0] m;
        begin
            merge = (old & ~m) | (nw & m);
        end
    endfunction

    // Settable 3-bit priority of a vector
    function [2:0] pri_of;
        input [5:0] v;
        reg   [5:0] idx;
        begin
            idx = v - `VEC_IRQ0;
            case (v)
                `VEC_MEM:   pri_of = syspri_reg[2:0];
                `VEC_BUS:   pri_of = syspri_reg[5:3];
                `VEC_USAGE: pri_of = syspri_reg[8:6];
                `VEC_SVC:   pri_of = syspri_reg[11:9];
                `VEC_DEBUG: pri_of = syspri_reg[14:12];
                `VEC_PSV:   pri_of = syspri_reg[17:15];
                `VEC_TICK:  pri_of = syspri_reg[20:18];
                default:    pri_of = irqpri_reg[{idx[4:0], 2'h0} +: 3];
            endcase
        end
    endfunction

    // Preempt rank; only the group part counts for nesting
    function [3:0] rank_of;
        input [5:0] v;
        reg   [2:0] pm;
        begin
            pm = pri_of(v) & (3'h7 << grp);
            case (v)
                `VEC_NMI:  rank_of = `RANK_NMI;
                `VEC_HARD: rank_of = `RANK_HARD;
                default:   rank_of = `RANK_SET + {1'b0, pm};
            endcase
        end
    endfunction

    // Current execution rank from reset hold and nesting
    always @* begin
        if (boot_reg) begin
            cur_rank = `RANK_RESET;
        end else if (depth_reg == 4'h0) begin
            cur_rank = `RANK_BASE;
        end else begin
            cur_rank = rank_stk[depth_m1];
        end
    end

    // Pick the pending, enabled vector with smallest key
    always @* begin
        best    = 13'h1fff;
        key     = 13'h1fff;
        win_vec = 6'h00;
        win_rank = `RANK_BASE;
        win_ok  = 1'b0;
        for (i = 2; i < 48; i = i + 1) begin
            if (pend_reg[i] && (i < 16 || enable_reg[i-16])) begin
                // Rank, then full priority, then vector number
                key = {rank_of(i[5:0]), pri_of(i[5:0]), i[5:0]};
                if (i < 4) begin
                    key[8:6] = 3'h0;
                end
                if (key < best) begin
                    best     = key;
                    win_vec  = i[5:0];
                    win_rank = key[12:9];
                    win_ok   = 1'b1;
                end
            end
        end
    end

    wire take = win_ok & (win_rank < cur_rank);

    // Peripheral lines pass two flip-flops
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_meta_reg <= 32'h00000000;
            irq_sync_reg <= 32'h00000000;
        end else begin
            irq_meta_reg <= irq_in;
            irq_sync_reg <= irq_meta_reg;
        end
    end

    // Pending flags: clears first, sets after so a set wins
    always @* begin
        pend_next = pend_reg;
        if (state_reg == S_RUN && take && !boot_reg && depth_reg < NEST) begin
            pend_next[win_vec] = 1'b0;
        end
        if (state_reg == S_RET && take) begin
            pend_next[win_vec] = 1'b0;
        end
        if (w_pclr) begin
            pend_next[47:16] = pend_next[47:16] & ~wbits;
        end
        if (w_ctrl && wbits[`CTRL_PSV_CLR]) begin
            pend_next[`VEC_PSV] = 1'b0;
        end
        // Peripheral levels pend while high
        pend_next[47:16] = pend_next[47:16] | irq_sync_reg;
        if (w_pset) begin
            pend_next[47:16] = pend_next[47:16] | wbits;
        end
        if (w_ctrl && wbits[`CTRL_NMI_SET]) begin
            pend_next[`VEC_NMI] = 1'b1;
        end
        if (w_ctrl && wbits[`CTRL_PSV_SET]) begin
            pend_next[`VEC_PSV] = 1'b1;
        end
        if (tick_fire) begin
            pend_next[`VEC_TICK] = 1'b1;
        end
        // Disabled faults, and blocked ones other than imprecise bus faults, escalate to hard fault
        if (fault_mem) begin
            if (ctrl_reg[`CTRL_MEM_EN] && rank_of(`VEC_MEM) < cur_rank) begin
                pend_next[`VEC_MEM] = 1'b1;
            end else begin
                pend_next[`VEC_HARD] = 1'b1;
            end
        end
        if (fault_bus_precise) begin
            if (ctrl_reg[`CTRL_BUS_EN] && rank_of(`VEC_BUS) < cur_rank) begin
                pend_next[`VEC_BUS] = 1'b1;
            end else begin
                pend_next[`VEC_HARD] = 1'b1;
            end
        end
        if (fault_bus_imprecise) begin
            // Imprecise faults wait pending for their turn
            if (ctrl_reg[`CTRL_BUS_EN]) begin
                pend_next[`VEC_BUS] = 1'b1;
            end else begin
                pend_next[`VEC_HARD] = 1'b1;
            end
        end
        if (fault_usage) begin
            if (ctrl_reg[`CTRL_USE_EN] && rank_of(`VEC_USAGE) < cur_rank) begin
                pend_next[`VEC_USAGE] = 1'b1;
            end else begin
                pend_next[`VEC_HARD] = 1'b1;
            end
        end
        if (svc_exec) begin
            if (rank_of(`VEC_SVC) < cur_rank) begin
                pend_next[`VEC_SVC] = 1'b1;
            end else begin
                pend_next[`VEC_HARD] = 1'b1;
            end
        end
        // Debug requests below current activation are dropped
        if (debug_req && ctrl_reg[`CTRL_DBG_EN] && rank_of(`VEC_DEBUG) < cur_rank) begin
            pend_next[`VEC_DEBUG] = 1'b1;
        end
        pend_next[1:0] = 2'h0;
    end

    // Software registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= `CTRL_RST;
            enable_reg <= 32'h00000000;
            syspri_reg <= {7{`PRI_RST}};
            irqpri_reg <= {32{1'b0, `PRI_RST}};
            pend_reg   <= 48'h000000000000;
        end else begin
            pend_reg <= pend_next;
            if (w_ctrl) begin
                ctrl_reg <= merge(ctrl_reg, wdata, wmask) & `CTRL_KEEP;
            end
            if (w_enable) begin
                enable_reg <= merge(enable_reg, wdata, wmask);
            end
            if (w_syspri) begin
                syspri_reg <= (syspri_reg & ~wmask[20:0]) | wbits[20:0];
            end
            if (w_irqpri) begin
                // Eight interrupts per word, 3 bits in each nibble
                irqpri_reg[{wa[3:2], 5'h00} +: 32] <= merge(irqpri_reg[{wa[3:2], 5'h00} +: 32],
                    wdata, wmask) & 32'h77777777;
            end
        end
    end

    // Read decode; unmapped addresses give an error
    always @* begin
        rd_hit  = 1'b1;
        rd_data = 32'h00000000;
        if (ra == `OFF_CTRL) begin
            rd_data = ctrl_reg;
        end else if (ra == `OFF_ENABLE) begin
            rd_data = enable_reg;
        end else if (ra == `OFF_PEND_SET || ra == `OFF_PEND_CLR) begin
            rd_data = pend_reg[47:16];
        end else if (ra == `OFF_SYSPRI) begin
            rd_data = {11'h000, syspri_reg};
        end else if (ra == `OFF_STATUS) begin
            rd_data = {8'h00, state_reg, depth_reg, cur_rank, win_ok, win_vec[5:0],
                (depth_reg == 4'h0) ? 6'h00 : vec_stk[depth_m1]};
        end else if (ra >= `OFF_IRQPRI0 && ra <= `OFF_IRQPRI3 && ra[1:0] == 2'h0) begin
            rd_data = irqpri_reg[{ra[3:2], 5'h00} +: 32];
        end else begin
            rd_hit = 1'b0;
        end
        wr_hit = (wa == `OFF_CTRL) | (wa == `OFF_ENABLE) | (wa == `OFF_PEND_SET) |
                 (wa == `OFF_PEND_CLR) | (wa == `OFF_SYSPRI) | (wa == `OFF_STATUS) |
                 ((wa >= `OFF_IRQPRI0) & (wa <= `OFF_IRQPRI3) & (wa[1:0] == 2'h0));
    end

    // Bus handshakes: address and data taken together
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `RESP_OKAY;
        end else begin
            awready <= wr_go;
            wready  <= wr_go;
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            arready <= rd_go;
            if (rd_go) begin
                rvalid <= 1'b1;
                rdata  <= rd_data;
                rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // Entry, return and tail-chain sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg     <= S_BOOT;
            depth_reg     <= 4'h0;
            boot_reg      <= 1'b1;
            sdone_reg     <= 1'b0;
            vdone_reg     <= 1'b0;
            sp_fetch      <= 1'b0;
            vector_fetch  <= 1'b0;
            fetch_vector  <= `VEC_SP;
            stack_push    <= 1'b0;
            stack_pop     <= 1'b0;
            tail_chain    <= 1'b0;
            handler_start <= 1'b0;
            handler_mode  <= 1'b0;
            exec_prio     <= `RANK_RESET;
        end else begin
            sp_fetch      <= 1'b0;
            vector_fetch  <= 1'b0;
            stack_push    <= 1'b0;
            stack_pop     <= 1'b0;
            tail_chain    <= 1'b0;
            handler_start <= 1'b0;
            exec_prio     <= cur_rank;
            handler_mode  <= (depth_reg != 4'h0);
            if (first_instr) begin
                boot_reg <= 1'b0;
            end
            case (state_reg)
                S_BOOT: begin
                    // Stack pointer from entry zero, then reset vector
                    if (!sdone_reg) begin
                        sp_fetch     <= 1'b1;
                        fetch_vector <= `VEC_SP;
                        sdone_reg    <= 1'b1;
                    end else if (vector_done && fetch_vector == `VEC_SP) begin
                        vector_fetch <= 1'b1;
                        fetch_vector <= `VEC_RESET;
                    end else if (vector_done) begin
                        sdone_reg <= 1'b0;
                        state_reg <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (take && !boot_reg && depth_reg < NEST) begin
                        // Push state and fetch vector together
                        stack_push             <= 1'b1;
                        vector_fetch           <= 1'b1;
                        fetch_vector           <= win_vec;
                        rank_stk[depth_reg]    <= win_rank;
                        vec_stk[depth_reg]     <= win_vec;
                        depth_reg              <= depth_reg + 4'h1;
                        sdone_reg              <= 1'b0;
                        vdone_reg              <= 1'b0;
                        state_reg              <= S_ENTRY;
                    end else if (handler_return && depth_reg != 4'h0) begin
                        depth_reg <= depth_m1;
                        state_reg <= S_RET;
                    end
                end
                S_ENTRY: begin
                    // Both halves may finish in any order
                    if ((sdone_reg | stack_done) && (vdone_reg | vector_done)) begin
                        handler_start <= 1'b1;
                        state_reg     <= S_RUN;
                    end else begin
                        sdone_reg <= sdone_reg | stack_done;
                        vdone_reg <= vdone_reg | vector_done;
                    end
                end
                S_RET: begin
                    if (take && depth_reg < NEST) begin
                        // Next handler without pop and re-push
                        tail_chain          <= 1'b1;
                        vector_fetch        <= 1'b1;
                        fetch_vector        <= win_vec;
                        rank_stk[depth_reg] <= win_rank;
                        vec_stk[depth_reg]  <= win_vec;
                        depth_reg           <= depth_reg + 4'h1;
                        sdone_reg           <= 1'b1;
                        vdone_reg           <= 1'b0;
                        state_reg           <= S_ENTRY;
                    end else begin
                        stack_pop <= 1'b1;
                        state_reg <= S_UNSTK;
                    end
                end
                S_UNSTK: begin
                    if (stack_done) begin
                        state_reg <= S_RUN;
                    end
                end
                default: begin
                    state_reg <= S_RUN;
                end
            endcase
        end
    end

endmodule

//--- verif/exception_prio_props.sv
// Concurrent checks on the core-side ports of the exception controller
`timescale 1ns/1ps
module exception_prio_props (
    input wire       aclk,
    input wire       aresetn,
    input wire       first_instr,
    input wire       handler_return,
    input wire       sp_fetch,
    input wire       vector_fetch,
    input wire [5:0] fetch_vector,
    input wire       stack_push,
    input wire       stack_pop,
    input wire       tail_chain,
    input wire       handler_start,
    input wire       handler_mode,
    input wire [3:0] exec_prio
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Vector read starts alongside the state save
    chk_push_fetch: assert property (stack_push |-> vector_fetch)
        else $error("state save without vector fetch");
    // Chained entry neither restores nor saves
    chk_tail_skip: assert property (tail_chain |-> vector_fetch && !stack_push && !stack_pop)
        else $error("chained entry touched the stack");
    // Stack pointer comes from entry zero
    chk_sp_vector: assert property (sp_fetch |-> fetch_vector == 6'h00)
        else $error("stack pointer fetch not at entry zero");
    // Leaving reset starts the stack pointer load
    chk_boot_sp: assert property ($rose(aresetn) |-> ##[1:3] sp_fetch)
        else $error("no stack pointer load after reset");
    // Only fixed ranks, settable ranks or base
    chk_rank_legal: assert property (exec_prio <= 4'ha || exec_prio == 4'hf)
        else $error("illegal execution rank");
    // First instruction drops to base level
    chk_base_level: assert property (first_instr && !handler_mode |-> ##2 exec_prio == 4'hf)
        else $error("rank not at base after first instruction");
    // Handler start means handler mode
    chk_mode_entry: assert property (handler_start |-> ##2 handler_mode)
        else $error("handler started outside handler mode");
    // Handler end restores or chains promptly
    chk_return_exit: assert property (handler_return && handler_mode |-> ##[1:4] (stack_pop || tail_chain))
        else $error("handler end without restore or chain");
    cov_tail: cover property (tail_chain);
    cov_pop: cover property (stack_pop);
    cov_start: cover property (handler_start);
endmodule

//--- verif/core_side_model.sv
// Core-side model: answers stack and vector requests, reports the first instruction
`timescale 1ns/1ps
module core_side_model (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire [3:0] lag,
    input  wire       sp_fetch,
    input  wire       vector_fetch,
    input  wire [5:0] fetch_vector,
    input  wire       stack_push,
    input  wire       stack_pop,
    output reg        stack_done,
    output reg        vector_done,
    output reg        first_instr
);
    reg [3:0] s_cnt; // Stack transfer countdown
    reg [3:0] v_cnt; // Vector read countdown
    reg       boot;  // Reset vector in flight
    // Each request ends lag+1 cycles later with a one-cycle pulse
    always @(posedge aclk) begin
        if (!aresetn) begin
            {s_cnt, v_cnt, boot, stack_done, vector_done, first_instr} <= 12'h000;
        end else begin
            s_cnt <= (stack_push || stack_pop) ? lag : s_cnt - (s_cnt != 4'h0);
            v_cnt <= (sp_fetch || vector_fetch) ? lag : v_cnt - (v_cnt != 4'h0);
            stack_done <= s_cnt == 4'h1;
            vector_done <= v_cnt == 4'h1;
            // Core runs its first instruction once the reset vector is read
            first_instr <= boot && vector_done;
            if (vector_fetch && fetch_vector == 6'h01) begin
                boot <= 1'b1;
            end else if (vector_done) begin
                boot <= 1'b0;
            end
        end
    end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the exception priority controller
`timescale 1ns/1ps
`include "exception_prio_map.vh"
`define CHK(g, e) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("BAD %0t got %h exp %h", $time, g, e); \
    end \
end
module testbench;
    reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, handler_return;
    reg  [7:0]  awaddr, araddr; // Register addresses
    reg  [31:0] wdata, irq_in;  // Write data, interrupt lines
    reg  [3:0]  wstrb, lag;     // Byte enables, model delay
    reg  [6:0]  ev;             // Core event pulses
    wire [31:0] rdata;
    wire [5:0]  fetch_vector;
    wire [3:0]  exec_prio;
    wire [1:0]  bresp, rresp;
    wire        awready, wready, bvalid, arready, rvalid, sp_fetch, vector_fetch;
    wire        stack_push, stack_pop, tail_chain, handler_start, handler_mode;
    wire        stack_done, vector_done, first_instr;
    integer     bad_count, n_tests, i, p;
    // Expected vector per event, one byte each; zero means the event is skipped
    localparam [143:0] tbl = {72'h0e020f0c0b06050504, 72'h00000f000b03030303};
    exception_priority_controller exception_priority_controller_i (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .irq_in, .fault_mem(ev[0]), .fault_bus_precise(ev[1]),
        .fault_bus_imprecise(ev[2]), .fault_usage(ev[3]), .svc_exec(ev[4]),
        .debug_req(ev[5]), .tick_fire(ev[6]), .first_instr, .stack_done, .vector_done,
        .handler_return, .sp_fetch, .vector_fetch, .fetch_vector, .stack_push,
        .stack_pop, .tail_chain, .handler_start, .handler_mode, .exec_prio);
    core_side_model core_side_model_i (.aclk, .aresetn, .lag, .sp_fetch, .vector_fetch,
        .fetch_vector, .stack_push, .stack_pop, .stack_done, .vector_done, .first_instr);
    // Clock and watchdog
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        #200000;
        bad_count++;
        complete_run;
    end
    // Bus write: address and data together, then response
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            do @(posedge aclk); while (awready !== 1'b1);
            awvalid <= 1'b0;
            wvalid <= 1'b0;
            while (bvalid !== 1'b1) @(posedge aclk);
            `CHK(bresp, r)
        end
    endtask
    // Bus read with data and response compare
    task rd(input [7:0] a, input [31:0] e, input [1:0] r);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            do @(posedge aclk); while (arready !== 1'b1);
            arvalid <= 1'b0;
            while (rvalid !== 1'b1) @(posedge aclk);
            `CHK(rdata, e)
            `CHK(rresp, r)
        end
    endtask
    // Entry: vector and kind, then wait for handler start
    task enter(input [5:0] e, input t);
        begin
            do @(posedge aclk); while (stack_push !== 1'b1 && tail_chain !== 1'b1);
            `CHK(fetch_vector, e)
            `CHK(tail_chain, t)
            do @(posedge aclk); while (handler_start !== 1'b1);
        end
    endtask
    // Handler end; without a chain wait for the restore
    task leave(input t);
        begin
            repeat (2) @(posedge aclk);
            `CHK(handler_mode, 1'b1)
            handler_return <= 1'b1;
            @(posedge aclk);
            handler_return <= 1'b0;
            if (!t) begin
                do @(posedge aclk); while (stack_pop !== 1'b1);
                repeat (8) @(posedge aclk);
            end
        end
    endtask
    // Raise one core event or control request and service it
    task run(input integer k, input [5:0] e);
        begin
            if (k < 7) begin
                ev <= 7'h01 << k;
                @(posedge aclk);
                ev <= 7'h00;
            end else begin
                wr(`OFF_CTRL, 32'h00000f00 | (k - 6), `RESP_OKAY);
            end
            enter(e, 1'b0);
            leave(1'b0);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d bad %0d", n_tests, bad_count);
            if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, handler_return} = 7'h0a;
        {awaddr, araddr, wdata, irq_in, ev} = 87'h0;
        wstrb = 4'hf;
        lag = 4'h1;
        bad_count = 0;
        n_tests = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (20) @(posedge aclk);
        rd(`OFF_SYSPRI, 32'h0, `RESP_OKAY);
        for (i = 0; i < 4; i++) rd(`OFF_IRQPRI0 + 8'(4 * i), 32'h0, `RESP_OKAY);
        wr(`OFF_SYSPRI, 32'hffffffff, `RESP_OKAY);
        rd(`OFF_SYSPRI, 32'h001fffff, `RESP_OKAY);
        wr(`OFF_IRQPRI0, 32'hffffffff, `RESP_OKAY);
        rd(`OFF_IRQPRI0, 32'h77777777, `RESP_OKAY);
        wr(8'h40, 32'h1, `RESP_SLVERR);
        rd(8'h40, 32'h0, `RESP_SLVERR);
        // Two lines at equal priority: lower position first, then chained
        wr(`OFF_CTRL, 32'h00000010, `RESP_OKAY);
        wr(`OFF_IRQPRI0, 32'h00000011, `RESP_OKAY);
        wr(`OFF_ENABLE, 32'h3, `RESP_OKAY);
        irq_in <= 32'h3;
        enter(`VEC_IRQ0, 1'b0);
        repeat (2) @(posedge aclk);
        `CHK(exec_prio, 4'h3)
        irq_in[0] <= 1'b0;
        repeat (4) @(posedge aclk);
        wr(`OFF_PEND_CLR, 32'h1, `RESP_OKAY);
        leave(1'b1);
        enter(`VEC_IRQ0 + 6'h01, 1'b1);
        irq_in[1] <= 1'b0;
        repeat (4) @(posedge aclk);
        wr(`OFF_PEND_CLR, 32'h2, `RESP_OKAY);
        leave(1'b0);
        `CHK(exec_prio, 4'hf)
        // Every core event but debug with handlers disabled, then all plus control requests with handlers enabled, slow core
        lag <= 4'h3;
        for (p = 0; p < 2; p++) begin
            wr(`OFF_CTRL, p ? 32'h00000f00 : 32'h0, `RESP_OKAY);
            for (i = 0; i < 9; i++) begin
                if (tbl[p * 72 + i * 8 +: 6] != 6'h00) run(i, tbl[p * 72 + i * 8 +: 6]);
            end
        end
        complete_run;
    end
endmodule
bind exception_priority_controller exception_prio_props exception_prio_props_i (
    .aclk, .aresetn, .first_instr, .handler_return, .sp_fetch, .vector_fetch,
    .fetch_vector, .stack_push, .stack_pop, .tail_chain, .handler_start,
    .handler_mode, .exec_prio);
